// File: design/ple_framer.sv
// Bit-stream pseudowire framer: header build, payload fill, header check
//
// Overview of operation
// - Control word first, RTP header right after
// - Control word top nibble sent as zero
// - Fault flag marks invalid payload, receiver replaces
// - Remote-loss flag follows loss or backward fault
// - Reserved and fragment bits sent zero, ignored
// - Length field zero; size checked against config
// - Control-word sequence rises by one per packet
// - RTP version always two
// - Padding, extension, count, marker sent zero
// - Payload type configured per direction
// - Sequence counts to maximum then wraps
// - Receiver drops late packets and fills gaps by control-word sequence
// - Timestamp at 125 MHz up to 200G
// - Timestamp at 250 MHz above 200G
// - Source identifier mismatch flags misconnection
// - Payload size fixed while pseudowire runs
// - Default payload size of 1024 bytes
// - Agnostic mode packs bits MSB first
// - Agnostic mapping offered for bit streams
// - Lanes arrive already deskewed and interleaved
// - Byte mode keeps circuit byte order
// - Lost payload replaced with 0xAA bytes
`timescale 1ns/1ps
`default_nettype none
module ple_framer
	import ple_pkg::*;
(
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic ac_bit_in,
	input wire logic ac_bit_valid_in,
	input wire logic [7:0] ac_byte_in,
	input wire logic ac_byte_valid_in,
	input wire logic ac_fault_in,
	input wire logic backward_fault_in,
	output logic [127:0] tx_hdr_out,
	output logic [7:0] tx_byte_out,
	output logic tx_valid_out,
	output logic tx_sop_out,
	output logic tx_eop_out,
	input wire logic [7:0] rx_byte_in,
	input wire logic rx_valid_in,
	input wire logic rx_sop_in,
	input wire logic rx_eop_in,
	output logic [7:0] ce_byte_out,
	output logic ce_valid_out,
	output logic ce_fault_out,
	output logic remote_loss_out
);
	logic [3:0] ctrl;
	logic [6:0] tx_pt;
	logic [6:0] rx_pt;
	logic [31:0] tx_ssrc;
	logic [31:0] rx_ssrc;
	logic [15:0] psize;
	logic [7:1] sticky;
	logic [7:1] sticky_set;
	logic [1:0] fault_sync;
	logic wb_req;
	logic [31:0] wmask;
	logic [31:0] tstamp;
	logic [PHASE_W-1:0] phase;
	logic [PHASE_W-1:0] phase_sum;
	logic [6:0] shift;
	logic [2:0] bit_cnt;
	logic [7:0] pbyte;
	logic byte_ready;
	logic [15:0] tx_idx;
	logic [15:0] tx_seq;
	logic [127:0] next_hdr;
	rx_state_type rx_state;
	logic [3:0] hdr_cnt;
	logic [127:0] rx_hdr;
	logic [127:0] hdr_full;
	logic [15:0] pay_cnt;
	logic [15:0] rx_expect;
	logic [15:0] rtp_last;
	logic synced;
	logic loss_state;
	logic [31:0] fill_cnt;
	logic [31:0] next_fill;
	logic hdr_last, is_cw, ver_ok, accept, ahead, late;
	logic pay_out, pay_last, short_end, long_end, hdr_short, emit_fill;
	logic [15:0] seq_diff;

	// Asynchronous fault inputs from the service processor
	ple_sync3 #(.WIDTH(2)) u_sync (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.async_in({backward_fault_in, ac_fault_in}),
		.sync_out(fault_sync)
	);

	// Byte-lane write mask
	assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old);
		merge = (old & ~wmask) | (wb_dat_in & wmask);
	endfunction

	// Bus handshake, one wait state then a single-cycle ack
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end else begin
			wb_ack_out <= wb_req;
			if (wb_req && !wb_we_in) begin
				unique case (wb_adr_in)
					ADDR_CTRL: wb_dat_out <= {28'h0, ctrl};
					ADDR_PTYPE: wb_dat_out <= {17'h0, rx_pt, 1'b0, tx_pt};
					ADDR_TX_SSRC: wb_dat_out <= tx_ssrc;
					ADDR_RX_SSRC: wb_dat_out <= rx_ssrc;
					ADDR_STATUS: wb_dat_out <= {24'h0, sticky, loss_state};
					ADDR_SEQ: wb_dat_out <= {rx_expect, tx_seq};
					ADDR_PSIZE: wb_dat_out <= {16'h0, psize};
					ADDR_TSTAMP: wb_dat_out <= tstamp;
					default: wb_dat_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Configuration registers
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl <= CTRL_RESET;
			tx_pt <= PT_RESET;
			rx_pt <= PT_RESET;
			tx_ssrc <= SSRC_RESET;
			rx_ssrc <= SSRC_RESET;
			psize <= PSIZE_RESET;
		end else if (wb_req && wb_we_in) begin
			if (wb_adr_in == ADDR_CTRL) begin
				ctrl <= (ctrl & ~wmask[3:0]) | (wb_dat_in[3:0] & wmask[3:0]);
			end
			if (wb_adr_in == ADDR_PTYPE) begin
				tx_pt <= (tx_pt & ~wmask[6:0]) | (wb_dat_in[6:0] & wmask[6:0]);
				rx_pt <= (rx_pt & ~wmask[14:8]) | (wb_dat_in[14:8] & wmask[14:8]);
			end
			if (wb_adr_in == ADDR_TX_SSRC) begin
				tx_ssrc <= merge(tx_ssrc);
			end
			if (wb_adr_in == ADDR_RX_SSRC) begin
				rx_ssrc <= merge(rx_ssrc);
			end
			if (wb_adr_in == ADDR_PSIZE && !ctrl[CTRL_ENABLE]) begin
				psize <= (psize & ~wmask[15:0]) | (wb_dat_in[15:0] & wmask[15:0]);
			end
		end
	end

	// Sticky status, a new event wins over a write-one clear
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sticky <= 7'h00;
		end else if (wb_req && wb_we_in && wb_adr_in == ADDR_STATUS && wb_sel_in[0]) begin
			sticky <= (sticky & ~wb_dat_in[7:1]) | sticky_set;
		end else begin
			sticky <= sticky | sticky_set;
		end
	end

	// Timestamp from a fractional accumulator of the reference rate
	assign phase_sum = phase + (ctrl[CTRL_HIGH_RATE] ? PHASE_W'(TS_HI_REM) : PHASE_W'(TS_LO_REM));
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase <= '0;
			tstamp <= 32'h0000_0000;
		end else if (phase_sum >= PHASE_W'(CLOCK_HZ)) begin
			phase <= phase_sum - PHASE_W'(CLOCK_HZ);
			tstamp <= tstamp + (ctrl[CTRL_HIGH_RATE] ? 32'(TS_HI_INT + 1) : 32'(TS_LO_INT + 1));
		end else begin
			phase <= phase_sum;
			tstamp <= tstamp + (ctrl[CTRL_HIGH_RATE] ? 32'(TS_HI_INT) : 32'(TS_LO_INT));
		end
	end

	// Payload byte packer; input arrives already lane-ordered and FEC-free
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			shift <= 7'h00;
			bit_cnt <= 3'h0;
			pbyte <= 8'h00;
			byte_ready <= 1'b0;
		end else begin
			byte_ready <= 1'b0;
			if (!ctrl[CTRL_ENABLE]) begin
				bit_cnt <= 3'h0;
			end else if (ctrl[CTRL_BYTE_MODE]) begin
				if (ac_byte_valid_in) begin
					pbyte <= ac_byte_in;
					byte_ready <= 1'b1;
				end
			end else if (ac_bit_valid_in) begin
				shift <= {shift[5:0], ac_bit_in};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					pbyte <= {shift, ac_bit_in};
					byte_ready <= 1'b1;
				end
			end
		end
	end

	// Header image: control word, then RTP header
	assign next_hdr = {CW_NIBBLE, fault_sync[0], loss_state || fault_sync[1],
		2'b00, 2'b00, 6'h00, tx_seq,
		RTP_VERSION, 1'b0, 1'b0, 4'h0, 1'b0, tx_pt, tx_seq,
		tstamp, tx_ssrc};

	// Packet emitter, header travels with the first payload byte
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_hdr_out <= '0;
			tx_byte_out <= 8'h00;
			tx_valid_out <= 1'b0;
			tx_sop_out <= 1'b0;
			tx_eop_out <= 1'b0;
			tx_idx <= 16'h0000;
			tx_seq <= 16'h0000;
		end else begin
			tx_valid_out <= byte_ready;
			tx_sop_out <= byte_ready && tx_idx == 16'h0000;
			tx_eop_out <= byte_ready && tx_idx == psize - 16'h1;
			if (!ctrl[CTRL_ENABLE]) begin
				tx_idx <= 16'h0000;
			end else if (byte_ready) begin
				tx_byte_out <= pbyte;
				if (tx_idx == 16'h0000) begin
					tx_hdr_out <= next_hdr;
				end
				if (tx_idx == psize - 16'h1) begin
					tx_idx <= 16'h0000;
					tx_seq <= tx_seq + 16'h1;
				end else begin
					tx_idx <= tx_idx + 16'h1;
				end
			end
		end
	end

	// Receive header decode
	assign hdr_full = {rx_hdr[119:0], rx_byte_in};
	assign hdr_last = rx_state == RX_HEADER && rx_valid_in && hdr_cnt == 4'(HDR_BYTES - 1);
	assign hdr_short = rx_state == RX_HEADER && rx_valid_in && rx_eop_in && !hdr_last;
	assign is_cw = hdr_full[127:124] == CW_NIBBLE;
	assign ver_ok = hdr_full[HDR_VER+:2] == RTP_VERSION;
	assign seq_diff = hdr_full[HDR_CW_SEQ+:16] - rx_expect;
	assign ahead = synced && seq_diff != 16'h0000 && !seq_diff[15];
	assign late = synced && seq_diff[15];
	assign accept = hdr_last && is_cw && ver_ok && !late;
	assign pay_out = rx_state == RX_PAYLOAD && rx_valid_in;
	assign pay_last = pay_cnt == psize - 16'h1;
	assign short_end = pay_out && rx_eop_in && !pay_last;
	assign long_end = pay_out && pay_last && !rx_eop_in;
	assign emit_fill = rx_state == RX_HEADER && !rx_valid_in && fill_cnt != 32'h0000_0000;
	assign next_fill = fill_cnt
		+ ((accept && ahead) ? 32'(seq_diff) * 32'(psize) : 32'h0000_0000)
		+ (short_end ? 32'(psize - 16'h1 - pay_cnt) : 32'h0000_0000)
		- 32'(emit_fill);

	// Event flags for status
	always_comb begin
		sticky_set = 7'h00;
		sticky_set[ST_MISCONN] = accept && ctrl[CTRL_SSRC_CHECK] && hdr_full[31:0] != rx_ssrc;
		sticky_set[ST_RX_FAULT] = accept && hdr_full[HDR_FAULT];
		sticky_set[ST_RX_RLOSS] = accept && hdr_full[HDR_RLOSS];
		sticky_set[ST_MALFORMED] = (hdr_last && is_cw && !ver_ok) || hdr_short || short_end || long_end;
		sticky_set[ST_RTP_SEQ] = accept && synced && hdr_full[HDR_RTP_SEQ+:16] != rtp_last + 16'h1;
		sticky_set[ST_PT_DIFF] = accept && hdr_full[HDR_PT+:7] != rx_pt;
		sticky_set[ST_MISORDER] = hdr_last && is_cw && ver_ok && late;
	end

	// Receive sequencer; reserved, fragment and length bits are not looked at
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_state <= RX_HEADER;
			hdr_cnt <= 4'h0;
			rx_hdr <= '0;
			pay_cnt <= 16'h0000;
			rx_expect <= 16'h0000;
			rtp_last <= 16'h0000;
			synced <= 1'b0;
			loss_state <= 1'b0;
			ce_fault_out <= 1'b0;
			remote_loss_out <= 1'b0;
		end else begin
			remote_loss_out <= loss_state;
			unique case (rx_state)
				RX_HEADER: begin
					if (rx_valid_in) begin
						rx_hdr <= hdr_full;
						hdr_cnt <= (rx_sop_in ? 4'h1 : hdr_cnt + 4'h1);
						if (hdr_short) begin
							hdr_cnt <= 4'h0;
							loss_state <= 1'b1;
						end else if (hdr_last) begin
							hdr_cnt <= 4'h0;
							if (accept) begin
								rx_state <= RX_PAYLOAD;
								pay_cnt <= 16'h0000;
								rx_expect <= hdr_full[HDR_CW_SEQ+:16] + 16'h1;
								rtp_last <= hdr_full[HDR_RTP_SEQ+:16];
								synced <= 1'b1;
								ce_fault_out <= hdr_full[HDR_FAULT];
								loss_state <= ahead;
							end else if (!rx_eop_in) begin
								rx_state <= RX_DISCARD;
							end
						end
					end
				end
				RX_PAYLOAD: begin
					if (pay_out) begin
						pay_cnt <= pay_cnt + 16'h1;
						if (rx_eop_in) begin
							rx_state <= RX_HEADER;
						end else if (long_end) begin
							rx_state <= RX_DISCARD;
						end
						if (short_end || long_end) begin
							loss_state <= 1'b1;
						end
					end
				end
				RX_DISCARD: begin
					if (rx_valid_in && rx_eop_in) begin
						rx_state <= RX_HEADER;
					end
				end
			endcase
		end
	end

	// Play-out toward the customer edge with replacement bytes
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ce_byte_out <= 8'h00;
			ce_valid_out <= 1'b0;
			fill_cnt <= 32'h0000_0000;
		end else begin
			fill_cnt <= next_fill;
			ce_valid_out <= pay_out || emit_fill;
			if (pay_out) begin
				ce_byte_out <= ce_fault_out ? REPLACEMENT_BYTE : rx_byte_in;
			end else if (emit_fill) begin
				ce_byte_out <= REPLACEMENT_BYTE;
			end
		end
	end

	// Checking helpers
	logic [15:0] chk_bytes;
	logic [15:0] chk_seq;
	logic chk_have;
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			chk_bytes <= 16'h0000;
			chk_seq <= 16'h0000;
			chk_have <= 1'b0;
		end else begin
			if (tx_valid_out) begin
				chk_bytes <= tx_sop_out ? 16'h0001 : chk_bytes + 16'h1;
			end
			if (tx_sop_out) begin
				chk_seq <= tx_hdr_out[HDR_CW_SEQ+:16];
				chk_have <= 1'b1;
			end
		end
	end

	a_cw_top_nibble: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tx_sop_out |-> tx_hdr_out[127:124] == 4'h0 && tx_valid_out)
		else $error("control word nibble not zero");
	a_cw_zero_fields: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tx_sop_out |-> tx_hdr_out[121:112] == 10'h000)
		else $error("reserved, fragment or length bits set");
	a_rtp_fixed_bits: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tx_sop_out |-> tx_hdr_out[95:87] == 9'h100 && tx_hdr_out[86:80] == $past(tx_pt))
		else $error("RTP first word fixed fields wrong");
	a_seq_step_one: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tx_sop_out && chk_have && $stable(ctrl) |-> tx_hdr_out[111:96] == chk_seq + 16'h1
			&& tx_hdr_out[79:64] == tx_hdr_out[111:96])
		else $error("sequence did not step by one");
	a_remote_loss_bit: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tx_sop_out |-> tx_hdr_out[HDR_RLOSS] == $past(loss_state || fault_sync[1]))
		else $error("remote-loss bit does not follow cause");
	a_fault_bit: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tx_sop_out |-> tx_hdr_out[HDR_FAULT] == $past(fault_sync[0]))
		else $error("fault bit does not follow fault input");
	a_payload_length: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tx_eop_out && !tx_sop_out |-> chk_bytes == psize - 16'h1)
		else $error("payload length differs from configured size");
	a_fill_pattern: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		emit_fill |=> ce_valid_out && ce_byte_out == 8'hAA)
		else $error("replacement byte missing or wrong");
	a_size_frozen: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		ctrl[CTRL_ENABLE] && $past(ctrl[CTRL_ENABLE]) |-> $stable(psize))
		else $error("payload size changed while running");
	a_ack_single: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// File: design/ple_sync3.sv
// Three-stage synchroniser that updates once the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module ple_sync3 #(
	parameter int WIDTH = 2
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// Capture chain, first stage feeds only the second
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Per-bit agreement filter
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clock_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				sync_out[i] <= 1'b0;
			end else if (stage2[i] == stage3[i]) begin
				sync_out[i] <= stage3[i];
			end
		end
	end
endmodule
`default_nettype wire

// File: shared/ple_pkg.sv
// Constants and types shared by the bit-stream pseudowire framer
package ple_pkg;
	// Clock and timestamp rates
	localparam int CLOCK_HZ = 40_000_000;
	localparam int TS_LO_HZ = 125_000_000;
	localparam int TS_HI_HZ = 250_000_000;
	localparam int TS_LO_INT = TS_LO_HZ / CLOCK_HZ;
	localparam int TS_LO_REM = TS_LO_HZ % CLOCK_HZ;
	localparam int TS_HI_INT = TS_HI_HZ / CLOCK_HZ;
	localparam int TS_HI_REM = TS_HI_HZ % CLOCK_HZ;
	localparam int PHASE_W = 27;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PTYPE = 8'h04;
	localparam logic [7:0] ADDR_TX_SSRC = 8'h08;
	localparam logic [7:0] ADDR_RX_SSRC = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SEQ = 8'h14;
	localparam logic [7:0] ADDR_PSIZE = 8'h18;
	localparam logic [7:0] ADDR_TSTAMP = 8'h1C;

	// Control bits
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_BYTE_MODE = 1;
	localparam int CTRL_HIGH_RATE = 2;
	localparam int CTRL_SSRC_CHECK = 3;

	// Status bits, bit 0 live, others sticky
	localparam int ST_LOSS = 0;
	localparam int ST_MISCONN = 1;
	localparam int ST_RX_FAULT = 2;
	localparam int ST_RX_RLOSS = 3;
	localparam int ST_MALFORMED = 4;
	localparam int ST_RTP_SEQ = 5;
	localparam int ST_PT_DIFF = 6;
	localparam int ST_MISORDER = 7;

	// Reset values
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [15:0] PSIZE_RESET = 16'h0400;
	localparam logic [6:0] PT_RESET = 7'h60;
	localparam logic [31:0] SSRC_RESET = 32'h0000_0000;

	// Header layout
	localparam int HDR_BYTES = 16;
	localparam logic [3:0] CW_NIBBLE = 4'h0;
	localparam logic [1:0] RTP_VERSION = 2'h2;
	localparam logic [7:0] REPLACEMENT_BYTE = 8'hAA;
	localparam int HDR_FAULT = 123;
	localparam int HDR_RLOSS = 122;
	localparam int HDR_CW_SEQ = 96;
	localparam int HDR_VER = 94;
	localparam int HDR_PT = 80;
	localparam int HDR_RTP_SEQ = 64;
	localparam int HDR_TS = 32;

	typedef enum logic [1:0] {RX_HEADER, RX_PAYLOAD, RX_DISCARD} rx_state_type;
endpackage

// File: tb/ple_far_end.sv
// Far-end interworking model: gathers sent packets, sends packets back
`timescale 1ns/1ps
`default_nettype none
module ple_far_end (
	input wire logic clock_in,
	input wire logic [127:0] tx_hdr_in,
	input wire logic [7:0] tx_byte_in,
	input wire logic tx_valid_in,
	input wire logic tx_sop_in,
	output logic [7:0] rx_byte_out,
	output logic rx_valid_out,
	output logic rx_sop_out,
	output logic rx_eop_out
);
	logic [7:0] got[$];
	logic [127:0] hdrs[$];
	// Idle receive lines
	initial begin
		rx_byte_out = 8'h00;
		rx_valid_out = 1'b0;
		rx_sop_out = 1'b0;
		rx_eop_out = 1'b0;
	end
	// Collect payload bytes and each packet header
	always @(posedge clock_in) begin
		if (tx_valid_in === 1'b1) begin
			got.push_back(tx_byte_in);
			if (tx_sop_in === 1'b1) begin
				hdrs.push_back(tx_hdr_in);
			end
		end
	end
	// Send one packet: header, then a counting payload of n bytes
	task automatic send(input logic [15:0] seq, input logic fault, input logic [31:0] ssrc,
		input int n, input logic [7:0] first);
		logic [127:0] hdr;
		hdr = {4'h0, fault, 11'h000, seq, 2'h2, 7'h00, 7'h61, seq, 32'h0, ssrc};
		for (int i = 0; i < 16 + n; i++) begin
			@(posedge clock_in);
			rx_byte_out <= (i < 16) ? hdr[127 - 8 * i -: 8] : first + 8'(i - 16);
			rx_valid_out <= 1'b1;
			rx_sop_out <= (i == 0);
			rx_eop_out <= (i == 15 + n);
		end
		@(posedge clock_in);
		rx_byte_out <= ~rx_byte_out; // Released lines show no stale value
		rx_valid_out <= 1'b0;
		rx_sop_out <= 1'b0;
		rx_eop_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: tb/test_bitstream_pw_encap.sv
// Testbench for the bit-stream pseudowire framer
`timescale 1ns/1ps
`default_nettype none
module test_bitstream_pw_encap;
	import ple_pkg::*;
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00, ac_byte = 8'h00, tx_byte, rx_byte, ce_byte;
	logic [31:0] wdat = 32'h0, wb_q, rdat, ts0;
	logic bit_d = 1'b0, bit_v = 1'b0, byte_v = 1'b0, fault = 1'b0, bfault = 1'b0;
	logic ack, tx_valid, tx_sop, rx_valid, rx_sop, rx_eop, ce_valid, ce_fault;
	logic tx_eop, rloss;
	int eop_n = 0;
	logic [127:0] tx_hdr;
	logic [7:0] ce_q[$];
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;

	// 40 MHz clock
	always #12.5 clock_in = ~clock_in;

	ple_framer dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF),
		.wb_dat_in(wdat), .wb_dat_out(wb_q), .wb_ack_out(ack), .ac_bit_in(bit_d),
		.ac_bit_valid_in(bit_v), .ac_byte_in(ac_byte), .ac_byte_valid_in(byte_v),
		.ac_fault_in(fault), .backward_fault_in(bfault), .tx_hdr_out(tx_hdr),
		.tx_byte_out(tx_byte), .tx_valid_out(tx_valid), .tx_sop_out(tx_sop),
		.tx_eop_out(tx_eop), .rx_byte_in(rx_byte), .rx_valid_in(rx_valid),
		.rx_sop_in(rx_sop), .rx_eop_in(rx_eop), .ce_byte_out(ce_byte),
		.ce_valid_out(ce_valid), .ce_fault_out(ce_fault), .remote_loss_out(rloss));

	ple_far_end far (.clock_in(clock_in), .tx_hdr_in(tx_hdr), .tx_byte_in(tx_byte),
		.tx_valid_in(tx_valid), .tx_sop_in(tx_sop), .rx_byte_out(rx_byte),
		.rx_valid_out(rx_valid), .rx_sop_out(rx_sop), .rx_eop_out(rx_eop));

	// Play-out bytes toward the customer edge
	always @(posedge clock_in) begin
		if (ce_valid === 1'b1) begin
			ce_q.push_back(ce_byte);
		end
		if (tx_eop === 1'b1) begin
			eop_n++;
		end
	end

	// Hang guard
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clock_in);
		while (ack !== 1'b1) @(posedge clock_in);
		rdat = wb_q;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask

	task automatic put_bytes(input logic [7:0] b0, input int cnt, input logic [7:0] step);
		for (int i = 0; i < cnt; i++) begin
			@(posedge clock_in);
			ac_byte <= b0 + step * 8'(i);
			byte_v <= 1'b1;
		end
		@(posedge clock_in);
		byte_v <= 1'b0;
	endtask

	task automatic put_bits(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(posedge clock_in);
			bit_d <= w[i];
			bit_v <= 1'b1;
		end
		@(posedge clock_in);
		bit_v <= 1'b0;
	endtask

	task automatic wait_tx(input int cnt);
		while (far.got.size() < cnt) @(posedge clock_in);
	endtask

	// Expected header of one sent packet
	task automatic check_hdr(input int k, input logic [15:0] seq, input logic f, input logic r);
		check(far.hdrs[k][127:64], {4'h0, f, r, 10'h000, seq, 2'h2, 7'h00, 7'h61, seq});
		check(far.hdrs[k][31:0], 32'hC0FFEE01);
	endtask

	// Timestamp advance over three cycles between two reads
	task automatic ts_check(input int lo, input int hi);
		wb(1'b0, ADDR_TSTAMP, 32'h0);
		ts0 = rdat;
		wb(1'b0, ADDR_TSTAMP, 32'h0);
		check((rdat - ts0) >= 32'(lo) && (rdat - ts0) <= 32'(hi), 1'b1);
	endtask

	task end_of_test;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clock_in);
		arst_n_in <= 1'b1;
		rd_check(ADDR_CTRL, 32'h0);
		rd_check(ADDR_PSIZE, 32'h0000_0400);
		rd_check(ADDR_PTYPE, 32'h0000_6060);
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		rd_check(8'h40, 32'h0);
		wb(1'b1, ADDR_PSIZE, 32'h4);
		wb(1'b1, ADDR_PTYPE, 32'h6161);
		wb(1'b1, ADDR_TX_SSRC, 32'hC0FFEE01);
		wb(1'b1, ADDR_RX_SSRC, 32'h5A5A0001);
		wb(1'b1, ADDR_CTRL, 32'h3);
		wb(1'b1, ADDR_PSIZE, 32'h8);
		rd_check(ADDR_PSIZE, 32'h4);
		// Byte mode, two packets back to back
		put_bytes(8'h81, 8, 8'h11);
		wait_tx(8);
		for (int i = 0; i < 8; i++) check(far.got[i], 8'h81 + 8'(17 * i));
		check_hdr(0, 16'h0, 1'b0, 1'b0);
		check_hdr(1, 16'h1, 1'b0, 1'b0);
		// Fault and backward fault raise then clear the flags
		fault <= 1'b1;
		bfault <= 1'b1;
		repeat (8) @(posedge clock_in);
		put_bytes(8'h00, 4, 8'h01);
		wait_tx(12);
		check_hdr(2, 16'h2, 1'b1, 1'b1);
		fault <= 1'b0;
		bfault <= 1'b0;
		repeat (8) @(posedge clock_in);
		put_bytes(8'h00, 4, 8'h01);
		wait_tx(16);
		check_hdr(3, 16'h3, 1'b0, 1'b0);
		ts_check(9, 10);
		wb(1'b1, ADDR_CTRL, 32'h7);
		ts_check(18, 19);
		// Agnostic mode packs bits first-arrived as top bit
		wb(1'b1, ADDR_CTRL, 32'h1);
		put_bits(32'hA53C_0FF0);
		wait_tx(20);
		check({far.got[16], far.got[17], far.got[18], far.got[19]}, 32'hA53C_0FF0);
		// Receive side: good packet, faulted packet, wrong source, late packet
		wb(1'b1, ADDR_CTRL, 32'h9);
		far.send(16'h0, 1'b0, 32'h5A5A0001, 4, 8'h10);
		far.send(16'h1, 1'b1, 32'h5A5A0001, 4, 8'h20);
		while (ce_q.size() < 8) @(posedge clock_in);
		check({ce_q[0], ce_q[1], ce_q[2], ce_q[3]}, 32'h1011_1213);
		check({ce_q[4], ce_q[5], ce_q[6], ce_q[7]}, 32'hAAAA_AAAA);
		check(ce_fault, 1'b1);
		far.send(16'h2, 1'b0, 32'h0BAD_0BAD, 4, 8'h30);
		repeat (4) @(posedge clock_in);
		wb(1'b0, ADDR_STATUS, 32'h0);
		check(rdat[ST_MISCONN], 1'b1);
		check(rdat[ST_MISORDER], 1'b0);
		n = ce_q.size();
		far.send(16'h1, 1'b0, 32'h5A5A0001, 4, 8'h40);
		repeat (4) @(posedge clock_in);
		wb(1'b0, ADDR_STATUS, 32'h0);
		check(rdat[ST_MISORDER], 1'b1);
		check(ce_q.size(), n);
		// Jump ahead reveals a lost packet: fill bytes and loss flag
		far.send(16'h4, 1'b0, 32'h5A5A0001, 4, 8'h50);
		while (ce_q.size() < n + 8) @(posedge clock_in);
		check({ce_q[n], ce_q[n + 1], ce_q[n + 2], ce_q[n + 3]}, 32'h5051_5253);
		check({ce_q[n + 4], ce_q[n + 5], ce_q[n + 6], ce_q[n + 7]}, 32'hAAAA_AAAA);
		check(rloss, 1'b1);
		put_bits(32'h0F0F_3C3C);
		wait_tx(24);
		repeat (2) @(posedge clock_in);
		check_hdr(5, 16'h5, 1'b0, 1'b1);
		check(eop_n, 6);
		end_of_test();
	end
endmodule
`default_nettype wire
